// ===== verilog/spi_port_regs.svh
// Register map, field positions, reset values and timing counts of the serial port
`ifndef SPI_PORT_REGS_SVH
`define SPI_PORT_REGS_SVH

// ---------------------------------------------------------------------------
// Register indices; the byte address is four times the index
// ---------------------------------------------------------------------------
`define CTRL_IDX          6'h0a
`define STAT_IDX          6'h0b
`define DATA_IDX          6'h0c
`define CTRL_ADDR         {`CTRL_IDX, 2'b00}
`define STAT_ADDR         {`STAT_IDX, 2'b00}
`define DATA_ADDR         {`DATA_IDX, 2'b00}

// ---------------------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------------------
`define CTRL_IE_BIT       7
`define CTRL_EN_BIT       6
`define CTRL_MASTER_SELECT_BIT_BIT     4
`define CTRL_CLOCK_IDLE_LEVEL_BIT     3
`define CTRL_CLOCK_SAMPLE_PHASE_BIT     2
`define CTRL_RATE_HI      1
`define CTRL_RATE_LO      0
`define CTRL_WMASK        8'hdf
`define CTRL_RESET        8'h00

// ---------------------------------------------------------------------------
// Status register fields
// ---------------------------------------------------------------------------
`define STAT_DONE_BIT     7
`define STAT_WRITE_COLLISION_FLAG_BIT     6
`define STAT_MODE_FAULT_FLAG_BIT     4

// ---------------------------------------------------------------------------
// Serial clock rates: processor clock divided by these figures
// ---------------------------------------------------------------------------
// The fastest rates leave MISO time to cross its two-stage synchroniser
// before the master's next sampling edge; dividers of 2 or 4 would not.
`define RATE_DIV0         8
`define RATE_DIV1         12
`define RATE_DIV2         16
`define RATE_DIV3         32
`define HALF0             5'((`RATE_DIV0) / 2)
`define HALF1             5'((`RATE_DIV1) / 2)
`define HALF2             5'((`RATE_DIV2) / 2)
`define HALF3             5'((`RATE_DIV3) / 2)
`define EDGES_PER_BYTE    5'd16
`define BITS_PER_BYTE     3'd7

`endif

// ===== verilog/spi_port_pkg.sv
// Types shared by the serial port design files
package spi_port_pkg;

  typedef enum logic {ST_IDLE, ST_RUN} mst_state_t;

  typedef enum logic [1:0] {SEL_CTRL, SEL_STAT, SEL_DATA, SEL_NONE} reg_sel_t;

  typedef struct packed {
    logic [7:0] ctrl;
    logic       done;
    logic       write_collision_flag;
    logic       mode_fault_flag;
    logic       stat_seen;
    logic       mode_fault_flag_seen;
    logic [7:0] shreg;
    logic [7:0] rbuf;
    logic       out_bit;
    logic       sck;
    logic [4:0] edge_cnt;
    logic [4:0] tick_cnt;
    mst_state_t mstate;
    logic [2:0] sbits;
    logic       sck_d;
    logic [7:0] prdata;
    logic       slverr;
  } port_state_t;

endpackage

// ===== verilog/spi_pin_sync.sv
// Two-stage synchroniser for the serial pins
`timescale 1ns/10ps
module spi_pin_sync #(
  parameter int          W       = 4,
  parameter logic [3:0]  RST_VAL = 4'h0
) (
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  input  wire logic [W-1:0] din_i,
  output logic      [W-1:0] dout_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_t;

  sync_t r;
  sync_t nxt;

  always_comb
  begin
    nxt.s1 = din_i;
    nxt.s2 = r.s1;
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      r.s1 <= RST_VAL[W-1:0];
      r.s2 <= RST_VAL[W-1:0];
    end
    else
    begin
      r <= nxt;
    end
  end

  assign dout_o = r.s2;

endmodule // spi_pin_sync

// ===== verilog/spi_port.sv
// Byte-wide full-duplex serial port, master or slave, with APB registers
//
// Behaviour
// - Master drives MOSI; slave reads MOSI.
// - Bytes shift most significant bit first.
// - Master samples MISO; slave drives MISO.
// - Slave MISO released while select high.
// - Master data leads its latch edge half-period.
// - Polarity and phase pick four timings.
// - One byte takes exactly eight clock pulses.
// - One shift register serves both directions.
// - Done flag set in status register.
// - Master bit set selects master role.
// - Master makes clock; slave follows input clock.
// - Two rate bits pick master rate.
// - Rate bits ignored in slave mode.
// - Master clock latches input, shifts output.
// - Write-collision and mode-fault flags exist.
// - Master seeing select low faults, disables.
// - Slave ignores clock and data unselected.
// - Idle master clock sits at polarity level.
// - Interrupt-enable bit gates done or fault onto interrupt.
`timescale 1ns/10ps
`include "spi_port_regs.svh"
module spi_port (
  input  wire logic        MCLK_I,
  input  wire logic        RST_B_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  input  wire logic        SCK_I,
  output logic             SCK_O,
  output logic             SCK_OE_O,
  input  wire logic        MOSI_I,
  output logic             MOSI_O,
  output logic             MOSI_OE_O,
  input  wire logic        MISO_I,
  output logic             MISO_O,
  output logic             MISO_OE_O,
  input  wire logic        SS_B_I,
  output logic             IRQ_O
);

  // -------------------------------------------------------------------------
  // Decoding helpers
  // -------------------------------------------------------------------------
  function automatic spi_port_pkg::reg_sel_t reg_sel(input logic [7:0] addr);
    if (addr == `CTRL_ADDR)
      return spi_port_pkg::SEL_CTRL;
    else if (addr == `STAT_ADDR)
      return spi_port_pkg::SEL_STAT;
    else if (addr == `DATA_ADDR)
      return spi_port_pkg::SEL_DATA;
    else
      return spi_port_pkg::SEL_NONE;
  endfunction

  function automatic logic [4:0] half_period(input logic [1:0] rate);
    case (rate)
      2'b00:   return `HALF0;
      2'b01:   return `HALF1;
      2'b10:   return `HALF2;
      default: return `HALF3;
    endcase
  endfunction

  // -------------------------------------------------------------------------
  // Pin synchronisers
  // -------------------------------------------------------------------------
  logic [3:0] pins_s;
  logic       sck_s;
  logic       mosi_s;
  logic       miso_s;
  logic       ss_b_s;

  // Select resets high so no false mode fault shows after reset
  spi_pin_sync #(
    .W       (4),
    .RST_VAL (4'h1)
  ) u_sync (
    .clk_i   (MCLK_I),
    .rst_b_i (RST_B_I),
    .din_i   ({SCK_I, MOSI_I, MISO_I, SS_B_I}),
    .dout_o  (pins_s)
  );

  assign sck_s  = pins_s[3];
  assign mosi_s = pins_s[2];
  assign miso_s = pins_s[1];
  assign ss_b_s = pins_s[0];

  // -------------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------------
  spi_port_pkg::port_state_t r;
  spi_port_pkg::port_state_t n;

  logic                   acc;
  logic                   setup;
  logic                   wr;
  logic                   rd;
  spi_port_pkg::reg_sel_t sel;
  logic                   en;
  logic                   master_select_bit;
  logic                   clock_idle_level;
  logic                   clock_sample_phase;
  logic                   slv_act;
  logic                   busy;
  logic                   tick;
  logic                   sample;
  logic                   lead;

  assign en      = r.ctrl[`CTRL_EN_BIT];
  assign master_select_bit    = r.ctrl[`CTRL_MASTER_SELECT_BIT_BIT];
  assign clock_idle_level    = r.ctrl[`CTRL_CLOCK_IDLE_LEVEL_BIT];
  assign clock_sample_phase    = r.ctrl[`CTRL_CLOCK_SAMPLE_PHASE_BIT];
  assign slv_act = en & ~master_select_bit & ~ss_b_s;

  // -------------------------------------------------------------------------
  // Next-state logic
  // -------------------------------------------------------------------------
  always_comb
  begin
    n      = r;
    setup  = PSEL_I & ~PENABLE_I;
    acc    = PSEL_I & PENABLE_I;
    wr     = acc & PWRITE_I;
    rd     = acc & ~PWRITE_I;
    sel    = reg_sel(PADDR_I);
    tick   = 1'b0;
    sample = 1'b0;
    lead   = 1'b0;
    // With phase zero a selected slave is busy before its first edge
    busy   = (r.mstate == spi_port_pkg::ST_RUN) |
             (slv_act & (~clock_sample_phase | (r.sbits != 3'd0)));

    // Read data is fetched in the setup cycle so it leaves a flip-flop
    if (setup)
    begin
      n.slverr = (sel == spi_port_pkg::SEL_NONE);
      case (sel)
        spi_port_pkg::SEL_CTRL: n.prdata = r.ctrl;
        spi_port_pkg::SEL_STAT: n.prdata = {r.done, r.write_collision_flag, 1'b0, r.mode_fault_flag, 4'h0};
        spi_port_pkg::SEL_DATA: n.prdata = r.rbuf;
        default:                n.prdata = 8'h00;
      endcase
    end

    // -----------------------------------------------------------------------
    // Software side effects; flag clears come first so events win below
    // -----------------------------------------------------------------------
    if (rd && sel == spi_port_pkg::SEL_STAT)
    begin
      if (r.done | r.write_collision_flag)
        n.stat_seen = 1'b1;
      if (r.mode_fault_flag)
        n.mode_fault_flag_seen = 1'b1;
    end
    if (acc && sel == spi_port_pkg::SEL_DATA && r.stat_seen)
    begin
      n.done      = 1'b0;
      n.write_collision_flag      = 1'b0;
      n.stat_seen = 1'b0;
    end
    if (wr && sel == spi_port_pkg::SEL_CTRL)
    begin
      n.ctrl = PWDATA_I[7:0] & `CTRL_WMASK;
      if (r.mode_fault_flag_seen)
      begin
        n.mode_fault_flag      = 1'b0;
        n.mode_fault_flag_seen = 1'b0;
      end
    end
    if (wr && sel == spi_port_pkg::SEL_DATA)
    begin
      if (busy)
        n.write_collision_flag = 1'b1;
      else
      begin
        n.shreg   = PWDATA_I[7:0];
        n.out_bit = PWDATA_I[7];
        if (en && master_select_bit)
        begin
          n.mstate   = spi_port_pkg::ST_RUN;
          n.edge_cnt = 5'd0;
          n.tick_cnt = 5'd0;
        end
      end
    end

    // -----------------------------------------------------------------------
    // Master engine: own clock from the processor clock
    // -----------------------------------------------------------------------
    if (r.mstate == spi_port_pkg::ST_RUN)
    begin
      if (r.tick_cnt == half_period(r.ctrl[`CTRL_RATE_HI:`CTRL_RATE_LO]) - 5'd1)
      begin
        tick       = 1'b1;
        n.tick_cnt = 5'd0;
      end
      else
        n.tick_cnt = r.tick_cnt + 5'd1;
      if (tick)
      begin
        if (r.edge_cnt == `EDGES_PER_BYTE)
        begin
          n.done   = 1'b1;
          n.rbuf   = r.shreg;
          n.mstate = spi_port_pkg::ST_IDLE;
        end
        else
        begin
          n.sck      = ~r.sck;
          n.edge_cnt = r.edge_cnt + 5'd1;
          // Even edges lead; phase picks which edge samples
          sample     = (r.edge_cnt[0] == clock_sample_phase);
          if (sample)
            n.shreg = {r.shreg[6:0], miso_s};
          else
            n.out_bit = r.shreg[7];
        end
      end
    end

    // -----------------------------------------------------------------------
    // Slave engine: follows the synchronised external clock
    // -----------------------------------------------------------------------
    n.sck_d = sck_s;
    if (!slv_act)
      n.sbits = 3'd0;
    else if (sck_s != r.sck_d)
    begin
      lead   = (sck_s != clock_idle_level);
      sample = lead ^ clock_sample_phase;
      if (sample)
      begin
        n.shreg = {r.shreg[6:0], mosi_s};
        n.sbits = r.sbits + 3'd1;
        if (r.sbits == `BITS_PER_BYTE)
        begin
          n.done = 1'b1;
          n.rbuf = {r.shreg[6:0], mosi_s};
        end
      end
      else
        n.out_bit = r.shreg[7];
    end

    // -----------------------------------------------------------------------
    // Mode fault: another master pulled our select low
    // -----------------------------------------------------------------------
    if (en && master_select_bit && !ss_b_s)
    begin
      n.ctrl[`CTRL_MASTER_SELECT_BIT_BIT] = 1'b0;
      n.ctrl[`CTRL_EN_BIT]   = 1'b0;
      n.mode_fault_flag                 = 1'b1;
    end

    // Disabling or leaving master role aborts a running byte
    if (!n.ctrl[`CTRL_EN_BIT] || !n.ctrl[`CTRL_MASTER_SELECT_BIT_BIT])
      n.mstate = spi_port_pkg::ST_IDLE;
    if (n.mstate == spi_port_pkg::ST_IDLE)
      n.sck = n.ctrl[`CTRL_CLOCK_IDLE_LEVEL_BIT];
  end

  // -------------------------------------------------------------------------
  // State register
  // -------------------------------------------------------------------------
  always_ff @(posedge MCLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      r.ctrl      <= `CTRL_RESET;
      r.done      <= 1'b0;
      r.write_collision_flag      <= 1'b0;
      r.mode_fault_flag      <= 1'b0;
      r.stat_seen <= 1'b0;
      r.mode_fault_flag_seen <= 1'b0;
      r.shreg     <= 8'h00;
      r.rbuf      <= 8'h00;
      r.out_bit   <= 1'b0;
      r.sck       <= 1'b0;
      r.edge_cnt  <= 5'd0;
      r.tick_cnt  <= 5'd0;
      r.mstate    <= spi_port_pkg::ST_IDLE;
      r.sbits     <= 3'd0;
      r.sck_d     <= 1'b0;
      r.prdata    <= 8'h00;
      r.slverr    <= 1'b0;
    end
    else
    begin
      r <= n;
    end
  end

  // -------------------------------------------------------------------------
  // Outputs
  // -------------------------------------------------------------------------
  assign PRDATA_O  = {24'h000000, r.prdata};
  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = PSEL_I & PENABLE_I & r.slverr;

  assign SCK_O     = r.sck;
  assign SCK_OE_O  = en & master_select_bit;
  assign MOSI_O    = r.out_bit;
  assign MOSI_OE_O = en & master_select_bit;
  assign MISO_O    = r.out_bit;
  assign MISO_OE_O = en & ~master_select_bit & ~ss_b_s;

  assign IRQ_O     = r.ctrl[`CTRL_IE_BIT] & (r.done | r.mode_fault_flag);

endmodule // spi_port

// ===== sim/spi_port_monitor.sv
// Checker bound to the serial port: pin roles, register bus and flag timing
`timescale 1ns/10ps
`include "spi_port_regs.svh"
module spi_port_monitor (
  input wire logic        MCLK_I,
  input wire logic        RST_B_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [7:0]  PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic        PREADY_O,
  input wire logic        PSLVERR_O,
  input wire logic        SCK_I,
  input wire logic        SCK_O,
  input wire logic        SCK_OE_O,
  input wire logic        MOSI_I,
  input wire logic        MOSI_O,
  input wire logic        MOSI_OE_O,
  input wire logic        MISO_I,
  input wire logic        MISO_O,
  input wire logic        MISO_OE_O,
  input wire logic        SS_B_I,
  input wire logic        IRQ_O
);
  // ------
  // Mirror of idle level and phase; a mode fault leaves both alone
  // ------
  logic [1:0] mode_r;
  always_ff @(posedge MCLK_I or negedge RST_B_I)
    if (!RST_B_I)
      mode_r <= 2'h0;
    else if (PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == `CTRL_ADDR)
      mode_r <= PWDATA_I[3:2];

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RST_B_I);

  property p_pready; PSEL_I && PENABLE_I |-> PREADY_O; endproperty
  a_pready: assert property (p_pready) else $error("access cycle without ready");
  property p_slverr;
    PSEL_I && PENABLE_I && !PWRITE_I && !(PADDR_I inside {`CTRL_ADDR, `STAT_ADDR, `DATA_ADDR})
      |-> PSLVERR_O && PRDATA_O == 32'h0;
  endproperty
  a_slverr: assert property (p_slverr) else $error("unmapped read not refused");
  property p_roles; SCK_OE_O == MOSI_OE_O && !(MOSI_OE_O && MISO_OE_O); endproperty
  a_roles: assert property (p_roles) else $error("pin roles mixed");
  property p_miso_off; SS_B_I [*4] |-> !MISO_OE_O; endproperty
  a_miso_off: assert property (p_miso_off) else $error("miso driven unselected");
  property p_mode_fault_flag; MOSI_OE_O && !SS_B_I |-> ##[1:5] !MOSI_OE_O; endproperty
  a_mode_fault_flag: assert property (p_mode_fault_flag) else $error("master kept driving");
  property p_irq;
    PSEL_I && !PENABLE_I && !PWRITE_I && PADDR_I == `STAT_ADDR && IRQ_O
      |=> PRDATA_O[7] || PRDATA_O[4];
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt without flag");
  property p_idle; $rose(SCK_OE_O) |=> SCK_O == mode_r[1]; endproperty
  a_idle: assert property (p_idle) else $error("clock not at idle level");
  property p_mosi_hold;
    SCK_OE_O && $past(SCK_OE_O) && $changed(SCK_O) && ((SCK_O != mode_r[1]) ^ mode_r[0])
      |-> $stable(MOSI_O);
  endproperty
  a_mosi_hold: assert property (p_mosi_hold) else $error("mosi moved at latch edge");

  c_irq: cover property ($rose(IRQ_O));
  c_fault: cover property ($fell(MOSI_OE_O));
  c_slave: cover property ($rose(MISO_OE_O));
endmodule // spi_port_monitor

bind spi_port spi_port_monitor mon (.MCLK_I, .RST_B_I, .PSEL_I, .PENABLE_I, .PWRITE_I,
  .PADDR_I, .PWDATA_I, .PRDATA_O, .PREADY_O, .PSLVERR_O, .SCK_I, .SCK_O, .SCK_OE_O,
  .MOSI_I, .MOSI_O, .MOSI_OE_O, .MISO_I, .MISO_O, .MISO_OE_O, .SS_B_I, .IRQ_O);

// ===== sim/spi_slave_model.sv
// Behavioural far-side serial device used while the port is master
`timescale 1ns/10ps
module spi_slave_model (
  input  wire logic sck_i,
  input  wire logic sel_b_i,
  input  wire logic mosi_i,
  input  wire logic clock_idle_level_i,
  input  wire logic clock_sample_phase_i,
  output logic      miso_o
);
  // ------
  // Shifter
  // ------
  logic [7:0] tx_r;
  logic [7:0] rx_r;
  int         k;
  initial miso_o = 1'b0;
  // Phase zero has no edge to launch bit 7, so select does it
  always @(negedge sel_b_i)
  begin
    k = clock_sample_phase_i ? 7 : 6;
    if (!clock_sample_phase_i)
      miso_o = tx_r[7];
  end
  // A released line must not keep the last bit
  always @(posedge sel_b_i)
    miso_o = ~miso_o;
  always @(sck_i)
    if (!sel_b_i)
    begin
      if ((sck_i != clock_idle_level_i) ^ clock_sample_phase_i)
        rx_r = {rx_r[6:0], mosi_i};
      else if (k >= 0)
      begin
        miso_o = tx_r[k];
        k = k - 1;
      end
    end
endmodule // spi_slave_model

// ===== sim/tb.sv
// Self-checking bench for the serial port
`timescale 1ns/10ps
`include "spi_port_regs.svh"
module tb;
  logic        clk, rst_b, psel, penable, pwrite, err, sck_t, mosi_t, ss_b, sel_b;
  logic        clock_idle_level, clock_sample_phase, pready, pslverr, sck_o, sck_oe, mosi_o, mosi_oe;
  logic        miso_o, miso_oe, miso_m, irq;
  logic [7:0]  paddr, d, e;
  logic [31:0] pwdata, prdata, rd;
  int          n_errors = 0, n_compared = 0, cyc = 0, seed = 33, lead_n, act_n;
  int          half[4] = '{`RATE_DIV0 / 2, `RATE_DIV1 / 2, `RATE_DIV2 / 2, `RATE_DIV3 / 2};

  spi_port uut (.MCLK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .SCK_I(sck_oe ? sck_o : sck_t), .SCK_O(sck_o),
    .SCK_OE_O(sck_oe), .MOSI_I(mosi_oe ? mosi_o : mosi_t), .MOSI_O(mosi_o),
    .MOSI_OE_O(mosi_oe), .MISO_I(miso_oe ? miso_o : miso_m), .MISO_O(miso_o),
    .MISO_OE_O(miso_oe), .SS_B_I(ss_b), .IRQ_O(irq));
  spi_slave_model pm (.sck_i(sck_oe ? sck_o : sck_t), .sel_b_i(sel_b), .mosi_i(mosi_o),
    .clock_idle_level_i(clock_idle_level), .clock_sample_phase_i(clock_sample_phase), .miso_o(miso_m));

  // ------
  // Clock, timeout and serial clock counters
  // ------
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(negedge clk)
  begin
    cyc++;
    if (sck_oe && sck_o !== clock_idle_level)
      act_n++;
    if (cyc == 20000)
    begin
      n_errors++;
      wrap_up();
    end
  end
  always @(sck_o)
    if (sck_oe && sck_o !== clock_idle_level)
      lead_n++;

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Request held until ready is seen at a rising edge; answer taken there
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task poll(input logic [7:0] mask);
    do
      apb(1'b0, `STAT_ADDR, 32'h0);
    while (!(rd[7:0] & mask));
  endtask
  task wrap_up();
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    {rst_b, psel, penable, pwrite, sck_t, mosi_t, clock_idle_level, clock_sample_phase} = 8'h00;
    {ss_b, sel_b, paddr, pwdata} = 42'h3_0000000000;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b0, `CTRL_ADDR, 32'h0);
    chk(rd, `CTRL_RESET);
    apb(1'b0, 8'h04, 32'h0);
    chk({rd[31:1], err}, 32'h1);
    apb(1'b1, `CTRL_ADDR, 32'hff);
    apb(1'b0, `CTRL_ADDR, 32'h0);
    chk(rd, 32'hdf);
    // Every idle level and phase, each with its own rate
    for (int m = 0; m < 4; m++)
    begin
      {clock_idle_level, clock_sample_phase} <= m[1:0];
      d = 8'($random(seed));
      e = 8'($random(seed));
      pm.tx_r = e;
      apb(1'b1, `CTRL_ADDR, {24'h0, 4'hd, m[1:0], m[1:0]});
      // Let the clock settle at its new idle level before selecting
      @(posedge clk);
      sel_b <= 1'b0;
      lead_n = 0;
      act_n = 0;
      apb(1'b1, `DATA_ADDR, {24'h0, d});
      apb(1'b1, `DATA_ADDR, {24'h0, ~d});
      poll(8'h80);
      chk(rd, 32'hc0);
      chk({31'h0, irq}, 32'h1);
      apb(1'b0, `DATA_ADDR, 32'h0);
      chk(rd, {24'h0, e});
      chk({24'h0, pm.rx_r}, {24'h0, d});
      chk(lead_n, 8);
      chk(act_n, 8 * half[m]);
      apb(1'b0, `STAT_ADDR, 32'h0);
      chk(rd, 32'h0);
      sel_b <= 1'b1;
    end
    // Select pulled low under an enabled master
    ss_b <= 1'b0;
    poll(8'h10);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, `CTRL_ADDR, 32'h0);
    chk(rd, 32'h8f);
    apb(1'b1, `CTRL_ADDR, 32'h43);
    apb(1'b0, `STAT_ADDR, 32'h0);
    chk(rd, 32'h0);
    // Slave exchange; phase zero refuses a data write while selected
    ss_b <= 1'b1;
    d = 8'($random(seed));
    e = 8'($random(seed));
    apb(1'b1, `DATA_ADDR, {24'h0, d});
    ss_b <= 1'b0;
    repeat (6) @(posedge clk);
    chk({29'h0, mosi_oe, sck_oe, miso_oe}, 32'h1);
    for (int i = 7; i >= 0; i--)
    begin
      mosi_t <= e[i];
      repeat (6) @(posedge clk);
      chk({31'h0, miso_o}, {31'h0, d[i]});
      sck_t <= 1'b1;
      repeat (6) @(posedge clk);
      sck_t <= 1'b0;
    end
    poll(8'h80);
    apb(1'b0, `DATA_ADDR, 32'h0);
    chk(rd, {24'h0, e});
    ss_b <= 1'b1;
    repeat (16)
    begin
      sck_t <= ~sck_t;
      repeat (6) @(posedge clk);
    end
    chk({31'h0, miso_oe}, 32'h0);
    apb(1'b0, `STAT_ADDR, 32'h0);
    chk(rd, 32'h0);
    wrap_up();
  end
endmodule // tb
